// ==== src/acd_clk_div_map.vh ====
`ifndef ACD_CLK_DIV_MAP_VH
`define ACD_CLK_DIV_MAP_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ACD_ADDR_MAIN_ADC      8'h3a
`define ACD_ADDR_DAC_HIGH      8'h3b
`define ACD_ADDR_PRI_LOW       8'h3c
`define ACD_ADDR_SEC_LOW       8'h3d

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACD_RST_MAIN_ADC       8'h04
`define ACD_RST_DAC_HIGH       8'h00
`define ACD_RST_PRI_LOW        8'h01
`define ACD_RST_SEC_LOW        8'h01
`define ACD_RDATA_NONE         8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACD_MAIN_HI            7
`define ACD_MAIN_LO            2
`define ACD_ADC_HI             1
`define ACD_ADC_LO             0
`define ACD_DAC_HI             5
`define ACD_DAC_LO             4
`define ACD_PRI_HIGH_BIT       2
`define ACD_SEC_HIGH_BIT       1
`define ACD_DAC_HIGH_MASK      8'h36

// ----------------------------------------------------------------
// ratio encodings
// ----------------------------------------------------------------
`define ACD_RATIO_W            10
`define ACD_MOD_CODE_DIV1      2'h0
`define ACD_MOD_CODE_DIV2      2'h1
`define ACD_MOD_CODE_DIV4      2'h2
`define ACD_MOD_CODE_RSVD      2'h3
`define ACD_RATIO_1            10'h001
`define ACD_RATIO_2            10'h002
`define ACD_RATIO_4            10'h004
`define ACD_RATIO_MAIN_ZERO    10'h040
`define ACD_RATIO_BCLK_ZERO    10'h200
`define ACD_MAIN_CODE_ZERO     6'h00
`define ACD_BCLK_CODE_ZERO     9'h000

`endif

// ==== src/acd_div_core.v ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// integer divider, ratio one upward
// ----------------------------------------------------------------
module acd_div_core #(
   parameter RW = 10
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire          en_i,
   input  wire [RW-1:0] ratio_i,
   output reg           clk_o,
   output reg           tick_o
);

   reg  [RW-1:0] cnt_ff;
   reg  [RW-1:0] nxt_cnt;
   wire [RW-1:0] ratio_m1;
   wire [RW-1:0] high_len;
   wire          last;

   assign ratio_m1 = ratio_i - {{(RW-1){1'b0}}, 1'b1};
   // high phase is the ceiling half, so odd ratios stay near even duty
   assign high_len = ratio_i - (ratio_i >> 1);
   // a ratio lowered mid-period wraps at once instead of overrunning
   assign last     = (cnt_ff >= ratio_m1);

   always @*
   begin
      if (last)
         nxt_cnt = {RW{1'b0}};
      else
         nxt_cnt = cnt_ff + {{(RW-1){1'b0}}, 1'b1};
   end

   always @(posedge clk_i)
   begin
      if (rst_i || !en_i)
      begin
         cnt_ff <= {RW{1'b0}};
         clk_o  <= 1'b0;
         tick_o <= 1'b0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         clk_o  <= (nxt_cnt < high_len);
         tick_o <= last;
      end
   end

endmodule

`default_nettype wire

// ==== src/acd_clk_div_cfg.v ====
// Function
// - main ratio code zero divides by 64, codes 1-63 divide by themselves
// - adc modulator ratio in bits 1-0: codes 0,1,2 divide by 1,2,4
// - dac modulator ratio in bits 5-4: codes 0,1,2 divide by 1,2,4
// - with auto detection on, register dividers are ignored
// - bit 2 of second register is primary bit-clock ratio top bit
// - bit 1 of second register is secondary bit-clock ratio top bit
// - bit-clock code zero divides by 512, others by their value
// - reserved bits read zero; host writes only zero there
// - split ratio is top bit concatenated above the low byte
// - primary bit-clock divider runs only while its enable is set
`timescale 1ns/1ps
`default_nettype none
`include "acd_clk_div_map.vh"

module acd_clk_div_cfg #(
   parameter RW = `ACD_RATIO_W
) (
   input  wire          clk_i,
   input  wire          rst_i,
   input  wire [7:0]    reg_addr_i,
   input  wire [7:0]    reg_wdata_i,
   input  wire          reg_wr_i,
   input  wire          reg_rd_i,
   output reg  [7:0]    reg_rdata_o,
   output reg           reg_rvalid_o,
   input  wire          auto_detect_en_i,
   input  wire [RW-1:0] auto_main_ratio_i,
   input  wire [RW-1:0] auto_adc_ratio_i,
   input  wire [RW-1:0] auto_dac_ratio_i,
   input  wire [RW-1:0] auto_primary_ratio_i,
   input  wire [RW-1:0] auto_secondary_ratio_i,
   input  wire          main_ratio_enable_i,
   input  wire          adc_modulator_enable_i,
   input  wire          dac_modulator_enable_i,
   input  wire          primary_bitclk_ratio_enable_i,
   input  wire          secondary_bitclk_ratio_enable_i,
   output wire          main_clk_o,
   output wire          main_tick_o,
   output wire          adc_mod_clk_o,
   output wire          adc_mod_tick_o,
   output wire          dac_mod_clk_o,
   output wire          dac_mod_tick_o,
   output wire          primary_bitclk_o,
   output wire          primary_bitclk_tick_o,
   output wire          secondary_bitclk_o,
   output wire          secondary_bitclk_tick_o,
   output reg           reserved_code_o
);

   // ----------------------------------------------------------------
   // decode functions
   // ----------------------------------------------------------------
   function [RW-1:0] mod_ratio;
      input [1:0] code;
      begin
         case (code)
            `ACD_MOD_CODE_DIV1: mod_ratio = `ACD_RATIO_1;
            `ACD_MOD_CODE_DIV2: mod_ratio = `ACD_RATIO_2;
            `ACD_MOD_CODE_DIV4: mod_ratio = `ACD_RATIO_4;
            // reserved code falls back to the divide-by-one bypass, the fastest ratio
            default:            mod_ratio = `ACD_RATIO_1;
         endcase
      end
   endfunction

   function is_rsvd_code;
      input [1:0] code;
      begin
         is_rsvd_code = (code == `ACD_MOD_CODE_RSVD);
      end
   endfunction

   function [RW-1:0] main_ratio;
      input [5:0] code;
      begin
         if (code == `ACD_MAIN_CODE_ZERO)
            main_ratio = `ACD_RATIO_MAIN_ZERO;
         else
            main_ratio = {{(RW-6){1'b0}}, code};
      end
   endfunction

   function [RW-1:0] bclk_ratio;
      input       high;
      input [7:0] low;
      reg   [8:0] code;
      begin
         code = {high, low};
         if (code == `ACD_BCLK_CODE_ZERO)
            bclk_ratio = `ACD_RATIO_BCLK_ZERO;
         else
            bclk_ratio = {{(RW-9){1'b0}}, code};
      end
   endfunction

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   reg  [7:0] main_adc_ff;
   reg  [7:0] dac_high_ff;
   reg  [7:0] pri_low_ff;
   reg  [7:0] sec_low_ff;
   reg  [7:0] nxt_rdata;

   wire [5:0] main_ratio_divider;
   wire [1:0] adc_modulator_ratio;
   wire [1:0] dac_modulator_ratio;
   wire       primary_bitclk_ratio_high;
   wire       secondary_bitclk_ratio_high;

   assign main_ratio_divider  = main_adc_ff[`ACD_MAIN_HI:`ACD_MAIN_LO];
   assign adc_modulator_ratio = main_adc_ff[`ACD_ADC_HI:`ACD_ADC_LO];
   assign dac_modulator_ratio = dac_high_ff[`ACD_DAC_HI:`ACD_DAC_LO];
   assign primary_bitclk_ratio_high   = dac_high_ff[`ACD_PRI_HIGH_BIT];
   assign secondary_bitclk_ratio_high = dac_high_ff[`ACD_SEC_HIGH_BIT];

   // ----------------------------------------------------------------
   // write port
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         main_adc_ff <= `ACD_RST_MAIN_ADC;
         dac_high_ff <= `ACD_RST_DAC_HIGH;
         pri_low_ff  <= `ACD_RST_PRI_LOW;
         sec_low_ff  <= `ACD_RST_SEC_LOW;
      end
      else if (reg_wr_i)
      begin
         case (reg_addr_i)
            `ACD_ADDR_MAIN_ADC:
               main_adc_ff <= reg_wdata_i;
            `ACD_ADDR_DAC_HIGH:
               // reserved positions never store, so they read zero
               dac_high_ff <= reg_wdata_i & `ACD_DAC_HIGH_MASK;
            `ACD_ADDR_PRI_LOW:
               pri_low_ff  <= reg_wdata_i;
            `ACD_ADDR_SEC_LOW:
               sec_low_ff  <= reg_wdata_i;
            default:
               main_adc_ff <= main_adc_ff;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always @*
   begin
      case (reg_addr_i)
         `ACD_ADDR_MAIN_ADC: nxt_rdata = main_adc_ff;
         `ACD_ADDR_DAC_HIGH: nxt_rdata = dac_high_ff;
         `ACD_ADDR_PRI_LOW:  nxt_rdata = pri_low_ff;
         `ACD_ADDR_SEC_LOW:  nxt_rdata = sec_low_ff;
         default:            nxt_rdata = `ACD_RDATA_NONE;
      endcase
   end

   // ----------------------------------------------------------------
   // read data register
   // ----------------------------------------------------------------
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         reg_rdata_o  <= `ACD_RDATA_NONE;
         reg_rvalid_o <= 1'b0;
      end
      else
      begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i)
            reg_rdata_o <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // ratio selection
   // ----------------------------------------------------------------
   wire [RW-1:0] cfg_main;
   wire [RW-1:0] cfg_adc;
   wire [RW-1:0] cfg_dac;
   wire [RW-1:0] cfg_pri;
   wire [RW-1:0] cfg_sec;
   reg  [RW-1:0] eff_main;
   reg  [RW-1:0] eff_adc;
   reg  [RW-1:0] eff_dac;
   reg  [RW-1:0] eff_pri;
   reg  [RW-1:0] eff_sec;

   assign cfg_main = main_ratio(main_ratio_divider);
   assign cfg_adc  = mod_ratio(adc_modulator_ratio);
   assign cfg_dac  = mod_ratio(dac_modulator_ratio);
   assign cfg_pri  = bclk_ratio(primary_bitclk_ratio_high, pri_low_ff);
   assign cfg_sec  = bclk_ratio(secondary_bitclk_ratio_high, sec_low_ff);

   // ----------------------------------------------------------------
   // effective ratios
   // ----------------------------------------------------------------
   always @*
   begin
      if (auto_detect_en_i)
      begin
         // detection owns every ratio; stored values are don't-care
         eff_main = auto_main_ratio_i;
         eff_adc  = auto_adc_ratio_i;
         eff_dac  = auto_dac_ratio_i;
         eff_pri  = auto_primary_ratio_i;
         eff_sec  = auto_secondary_ratio_i;
      end
      else
      begin
         eff_main = cfg_main;
         eff_adc  = cfg_adc;
         eff_dac  = cfg_dac;
         eff_pri  = cfg_pri;
         eff_sec  = cfg_sec;
      end
   end

   // ----------------------------------------------------------------
   // reserved code flag
   // ----------------------------------------------------------------
   reg nxt_rsvd;

   // flagged only when applied; under detection the codes are unused
   always @*
   begin
      nxt_rsvd = !auto_detect_en_i &&
         (is_rsvd_code(adc_modulator_ratio) ||
          is_rsvd_code(dac_modulator_ratio));
   end

   always @(posedge clk_i)
   begin
      if (rst_i)
         reserved_code_o <= 1'b0;
      else
         reserved_code_o <= nxt_rsvd;
   end

   // ----------------------------------------------------------------
   // dividers
   // ----------------------------------------------------------------
   acd_div_core #(
      .RW (RW)
   ) u_main_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (main_ratio_enable_i),
      .ratio_i (eff_main),
      .clk_o   (main_clk_o),
      .tick_o  (main_tick_o)
   );

   acd_div_core #(
      .RW (RW)
   ) u_adc_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (adc_modulator_enable_i),
      .ratio_i (eff_adc),
      .clk_o   (adc_mod_clk_o),
      .tick_o  (adc_mod_tick_o)
   );

   acd_div_core #(
      .RW (RW)
   ) u_dac_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (dac_modulator_enable_i),
      .ratio_i (eff_dac),
      .clk_o   (dac_mod_clk_o),
      .tick_o  (dac_mod_tick_o)
   );

   // held at zero count while disabled
   acd_div_core #(
      .RW (RW)
   ) u_pri_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (primary_bitclk_ratio_enable_i),
      .ratio_i (eff_pri),
      .clk_o   (primary_bitclk_o),
      .tick_o  (primary_bitclk_tick_o)
   );

   acd_div_core #(
      .RW (RW)
   ) u_sec_div (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .en_i    (secondary_bitclk_ratio_enable_i),
      .ratio_i (eff_sec),
      .clk_o   (secondary_bitclk_o),
      .tick_o  (secondary_bitclk_tick_o)
   );

endmodule

`default_nettype wire

// ==== tb/acd_clk_div_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// port-level checks of the divider config
// ---------------------------------------------
module acd_clk_div_chk (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic       reg_wr_i,
   input wire logic       reg_rd_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic       reg_rvalid_o,
   input wire logic       auto_detect_en_i,
   input wire logic       main_ratio_enable_i,
   input wire logic       primary_bitclk_ratio_enable_i,
   input wire logic       main_clk_o,
   input wire logic       main_tick_o,
   input wire logic       dac_mod_clk_o,
   input wire logic       dac_mod_tick_o,
   input wire logic       primary_bitclk_o,
   input wire logic       primary_bitclk_tick_o,
   input wire logic       reserved_code_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read strobe not answered");
   rvalid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i))
      else $error("read valid without a read");
   unmapped_zero_a: assert property (reg_rd_i && (reg_addr_i < 8'h3a ||
      reg_addr_i > 8'h3d) |=> reg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
   rsvd_bits_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h3b
      |=> (reg_rdata_o & 8'hc9) == 8'h00) else $error("reserved bit set");
   rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved without a read");
   low_byte_store_a: assert property (reg_wr_i && reg_addr_i == 8'h3c
      ##1 !reg_wr_i ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h3c
      |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("low byte not stored");
   pri_off_a: assert property (!primary_bitclk_ratio_enable_i
      |=> !primary_bitclk_o && !primary_bitclk_tick_o)
      else $error("primary divider runs while disabled");
   main_off_a: assert property (!main_ratio_enable_i
      |=> !main_clk_o && !main_tick_o) else $error("main divider runs off");
   tick_high_a: assert property (dac_mod_tick_o |-> dac_mod_clk_o)
      else $error("tick outside high phase");
   auto_flag_a: assert property (auto_detect_en_i |=> !reserved_code_o)
      else $error("reserved flag under auto detection");
endmodule
bind acd_clk_div_cfg acd_clk_div_chk chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
   .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .reg_rvalid_o(reg_rvalid_o), .auto_detect_en_i(auto_detect_en_i),
   .main_ratio_enable_i(main_ratio_enable_i),
   .primary_bitclk_ratio_enable_i(primary_bitclk_ratio_enable_i),
   .main_clk_o(main_clk_o), .main_tick_o(main_tick_o),
   .dac_mod_clk_o(dac_mod_clk_o), .dac_mod_tick_o(dac_mod_tick_o),
   .primary_bitclk_o(primary_bitclk_o),
   .primary_bitclk_tick_o(primary_bitclk_tick_o),
   .reserved_code_o(reserved_code_o));
`default_nettype wire

// ==== tb/acd_clk_div_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "acd_clk_div_map.vh"
module testbench;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00;
   logic       wr = 1'b0, rd = 1'b0, auto_en = 1'b0;
   logic [9:0] ar [5] = '{10'h001, 10'h001, 10'h001, 10'h001, 10'h001};
   logic [4:0] en = 5'h00;
   wire  [7:0] rdata;
   wire        rvalid, rsv;
   wire  [4:0] clk_o, tick_o;
   int         err_count = 0, samples_checked = 0;
   always #50 clk_i = ~clk_i;
   acd_clk_div_cfg #(.RW(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .auto_detect_en_i(auto_en),
      .auto_main_ratio_i(ar[0]), .auto_adc_ratio_i(ar[1]),
      .auto_dac_ratio_i(ar[2]), .auto_primary_ratio_i(ar[3]),
      .auto_secondary_ratio_i(ar[4]), .main_ratio_enable_i(en[0]),
      .adc_modulator_enable_i(en[1]), .dac_modulator_enable_i(en[2]),
      .primary_bitclk_ratio_enable_i(en[3]),
      .secondary_bitclk_ratio_enable_i(en[4]),
      .main_clk_o(clk_o[0]), .main_tick_o(tick_o[0]),
      .adc_mod_clk_o(clk_o[1]), .adc_mod_tick_o(tick_o[1]),
      .dac_mod_clk_o(clk_o[2]), .dac_mod_tick_o(tick_o[2]),
      .primary_bitclk_o(clk_o[3]), .primary_bitclk_tick_o(tick_o[3]),
      .secondary_bitclk_o(clk_o[4]), .secondary_bitclk_tick_o(tick_o[4]),
      .reserved_code_o(rsv));
   // ---------------------------------------------
   // expectations and bus tasks
   // ---------------------------------------------
   function automatic int main_r(input logic [5:0] c);
      return (c == 6'h00) ? 64 : int'(c);
   endfunction
   function automatic int mod_r(input logic [1:0] c);
      return (c == 2'h3) ? 1 : (1 << c);
   endfunction
   function automatic int bclk_r(input logic [8:0] c);
      return (c == 9'h000) ? 512 : int'(c);
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // extra edge after each strobe so a strobe never toggles twice at once
   task automatic wr_reg(input logic [7:0] a, d);
      addr <= a; wdata <= d; wr <= 1'b1;
      @(posedge clk_i);
      wr <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd_chk(input logic [7:0] a, exp);
      addr <= a; rd <= 1'b1;
      @(posedge clk_i);
      rd <= 1'b0;
      #1;
      check({15'h0, rvalid}, 16'h1, "read valid");
      check({8'h0, rdata}, {8'h0, exp}, "read data");
      @(posedge clk_i);
   endtask
   // third tick gap measured: first may be cut short by a ratio change
   task automatic period_chk(input int i, input int exp);
      int n, k, h;
      for (k = 0; k < 3; k++)
      begin
         n = 0;
         h = 0;
         do
         begin
            @(negedge clk_i);
            n++;
            if (clk_o[i] === 1'b1)
               h++;
         end
         while (tick_o[i] !== 1'b1 && n < 1100);
         if (n >= 1100)
         begin
            err_count++;
            $display("[FAIL] %0t divider %0d gives no tick", $time, i);
            summarize();
         end
      end
      check(16'(n), 16'(exp), "divider period");
      check(16'(h), 16'((exp + 1) / 2), "divider high phase");
      @(posedge clk_i);
   endtask
   initial
   begin
      logic [8:0] p, s;
      logic [5:0] m;
      int i;
      i = $urandom(32'h2768);
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(`ACD_ADDR_MAIN_ADC, 8'h04);
      rd_chk(`ACD_ADDR_DAC_HIGH, 8'h00);
      rd_chk(`ACD_ADDR_PRI_LOW, 8'h01);
      rd_chk(`ACD_ADDR_SEC_LOW, 8'h01);
      wr_reg(8'h3e, 8'h5a);
      rd_chk(8'h3e, 8'h00);
      wr_reg(`ACD_ADDR_DAC_HIGH, 8'hff);
      rd_chk(`ACD_ADDR_DAC_HIGH, 8'h36);
      en <= 5'h1f;
      for (i = 0; i < 6; i++)
      begin
         m = (i == 0) ? 6'h00 : (i == 1) ? 6'h3f : 6'($urandom);
         wr_reg(`ACD_ADDR_MAIN_ADC, {m, 2'h0});
         period_chk(0, main_r(m));
      end
      for (i = 0; i < 4; i++)
      begin
         wr_reg(`ACD_ADDR_MAIN_ADC, {6'h02, 2'(i)});
         wr_reg(`ACD_ADDR_DAC_HIGH, {2'h0, 2'(3 - i), 4'h0});
         period_chk(1, mod_r(2'(i)));
         period_chk(2, mod_r(2'(3 - i)));
         @(negedge clk_i);
         check({15'h0, rsv}, {15'h0, i == 0 || i == 3}, "reserved code");
         @(posedge clk_i);
      end
      for (i = 0; i < 6; i++)
      begin
         p = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($urandom);
         s = (i == 0) ? 9'h1ff : (i == 1) ? 9'h000 : 9'($urandom);
         wr_reg(`ACD_ADDR_DAC_HIGH, {5'h00, p[8], s[8], 1'b0});
         wr_reg(`ACD_ADDR_PRI_LOW, p[7:0]);
         rd_chk(`ACD_ADDR_PRI_LOW, p[7:0]);
         wr_reg(`ACD_ADDR_SEC_LOW, s[7:0]);
         period_chk(3, bclk_r(p));
         period_chk(4, bclk_r(s));
      end
      en[3] <= 1'b0;
      for (i = 0; i < 40; i++)
      begin
         @(negedge clk_i);
         if (i > 2) check({14'h0, clk_o[3], tick_o[3]}, 16'h0, "disabled");
      end
      @(posedge clk_i);
      en[3] <= 1'b1;
      wr_reg(`ACD_ADDR_MAIN_ADC, 8'h0b);
      auto_en <= 1'b1;
      for (i = 0; i < 5; i++)
         ar[i] <= 10'(1 + $urandom_range(599));
      @(posedge clk_i);
      for (i = 0; i < 5; i++)
         period_chk(i, int'(ar[i]));
      @(negedge clk_i);
      check({15'h0, rsv}, 16'h0, "reserved under auto");
      @(posedge clk_i);
      auto_en <= 1'b0;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check({4'h0, rvalid, rsv, clk_o, tick_o}, 16'h0, "reset");
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_chk(`ACD_ADDR_PRI_LOW, 8'h01);
      rd_chk(`ACD_ADDR_MAIN_ADC, 8'h04);
      summarize();
   end
endmodule
`default_nettype wire
